// >>> waveform_sequence_slots.sv
// Waveform slot sequencer: slot registers, trigger and playback walk
//
// Behaviour
// RQ1: Flag bit seven makes slot an idle wait
// RQ2: Wait lasts ten milliseconds times field value
// RQ3: Clear flag means field is library index
// RQ4: Trigger starts the walk at first slot
// RQ5: Advance after waveform ends if next nonzero
// RQ6: Stop at zero entry or after eight
// RQ7: Zero entry stops, plays nothing
// RQ8: Wait gaps honoured before moving on
// RQ9: Expired wait counts as played, then continue
module waveform_sequence_slots
	import seq_slots_pkg::*;
#(
	parameter int STEP_CYCLES = DELAY_STEP_CYCLES
)(
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	output logic      [6:0] wave_index_o,
	output logic            wave_start_o,
	input  wire logic       wave_done_i,
	output logic            playing_o,
	output logic            idling_o
);
	// ----------------------------------------------------------------
	// Register access
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_FETCH = 5'b00010,
		S_DECO  = 5'b00100,
		S_PLAY  = 5'b01000,
		S_WAIT  = 5'b10000
	} seq_state_e;

	seq_state_e state_q, state_d;
	logic [2:0]  idx_q, idx_d;
	logic [6:0]  steps_q, steps_d;
	logic [31:0] tick_q, tick_d;
	logic [7:0]  rdata_d;
	logic [7:0]  slot_data;
	logic [7:0]  trig_q, trig_d;
	logic        slot_hit;
	logic [2:0]  wr_idx;
	logic [7:0]  shadow_q [SLOT_COUNT];
	logic [7:0]  shadow_d [SLOT_COUNT];
	logic [6:0]  widx_d;
	logic        wstart_d, playing_d, idling_d;

	assign slot_hit = (reg_addr_i >= FIRST_SLOT_OFFSET) && (reg_addr_i <= LAST_SLOT_OFFSET);
	assign wr_idx   = 3'(reg_addr_i - FIRST_SLOT_OFFSET);

	slot_store #(.DEPTH(SLOT_COUNT)) i_slot_store (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.wr_en_i    (reg_wr_i && slot_hit),
		.wr_idx_i   (wr_idx),
		.wr_data_i  (reg_wdata_i),
		.rd_idx_i   (idx_q),
		.rd_data_o  (slot_data)
	);

	// Shadow copy serves host reads so the sequencer owns the memory read port
	always_comb
	begin
		for (int i = 0; i < SLOT_COUNT; i++)
		begin
			shadow_d[i] = shadow_q[i];
		end
		if (reg_wr_i && slot_hit)
		begin
			shadow_d[wr_idx] = reg_wdata_i;
		end
		trig_d = trig_q;
		if (state_q == S_IDLE && trig_q[TRIGGER_BIT])
		begin
			trig_d[TRIGGER_BIT] = 1'b0;
		end
		if (state_q != S_IDLE && state_d == S_IDLE)
		begin
			trig_d[TRIGGER_BIT] = 1'b0;
		end
		if (reg_wr_i && reg_addr_i == TRIGGER_OFFSET)
		begin
			trig_d = reg_wdata_i;
		end
		rdata_d = 8'h00;
		if (reg_rd_i)
		begin
			if (slot_hit)
			begin
				rdata_d = shadow_q[wr_idx];
			end
			else if (reg_addr_i == TRIGGER_OFFSET)
			begin
				rdata_d = {trig_q[7:1], (state_q != S_IDLE)};
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d   = state_q;
		idx_d     = idx_q;
		steps_d   = steps_q;
		tick_d    = tick_q;
		widx_d    = wave_index_o;
		wstart_d  = 1'b0;
		playing_d = 1'b0;
		idling_d  = 1'b0;
		case (state_q)
			S_IDLE:
			begin
				if (trig_q[TRIGGER_BIT])
				begin
					idx_d   = 3'h0;   // see RQ4
					state_d = S_FETCH;
				end
			end
			S_FETCH:
			begin
				state_d = S_DECO;
			end
			S_DECO:
			begin
				if (slot_data == 8'h00)
				begin
					state_d = S_IDLE;  // see RQ7
				end
				else if (slot_data[DELAY_FLAG_BIT])
				begin
					steps_d = slot_data[ENTRY_MSB:0];  // see RQ1
					tick_d  = 32'h0;
					state_d = S_WAIT;
				end
				else
				begin
					widx_d   = slot_data[ENTRY_MSB:0];  // see RQ3
					wstart_d = 1'b1;
					state_d  = S_PLAY;
				end
			end
			S_PLAY:
			begin
				playing_d = 1'b1;
				if (wave_done_i)
				begin
					playing_d = 1'b0;
					if (idx_q == 3'(SLOT_COUNT - 1))
					begin
						state_d = S_IDLE;  // see RQ6
					end
					else
					begin
						idx_d   = idx_q + 3'h1;  // see RQ5
						state_d = S_FETCH;
					end
				end
			end
			S_WAIT:
			begin
				idling_d = 1'b1;
				if (steps_q == 7'h00)
				begin
					idling_d = 1'b0;
					if (idx_q == 3'(SLOT_COUNT - 1))
					begin
						state_d = S_IDLE;  // see RQ6
					end
					else
					begin
						idx_d   = idx_q + 3'h1;  // see RQ9
						state_d = S_FETCH;
					end
				end
				else if (tick_q == 32'(STEP_CYCLES - 1))
				begin
					tick_d  = 32'h0;
					steps_d = steps_q - 7'h1;  // see RQ2
				end
				else
				begin
					tick_d = tick_q + 32'h1;  // see RQ8
				end
			end
			default:
			begin
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q      <= S_IDLE;
			idx_q        <= 3'h0;
			steps_q      <= 7'h00;
			tick_q       <= 32'h0;
			trig_q       <= 8'h00;
			reg_rdata_o  <= 8'h00;
			wave_index_o <= 7'h00;
			wave_start_o <= 1'b0;
			playing_o    <= 1'b0;
			idling_o     <= 1'b0;
			for (int i = 0; i < SLOT_COUNT; i++)
			begin
				shadow_q[i] <= SLOT_RESET;
			end
		end
		else
		begin
			state_q      <= state_d;
			idx_q        <= idx_d;
			steps_q      <= steps_d;
			tick_q       <= tick_d;
			trig_q       <= trig_d;
			reg_rdata_o  <= rdata_d;
			wave_index_o <= widx_d;
			wave_start_o <= wstart_d;
			playing_o    <= playing_d;
			idling_o     <= idling_d;
			shadow_q     <= shadow_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	start_first_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RQ4
		(state_q == S_IDLE && trig_q[TRIGGER_BIT]) |=> (state_q == S_FETCH && idx_q == 3'h0))
		else $error("trigger did not start at first slot");
	zero_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RQ7
		(state_q == S_DECO && slot_data == 8'h00) |=> (state_q == S_IDLE && !wave_start_o))
		else $error("zero entry did not stop");
	wait_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RQ1
		(state_q == S_DECO && slot_data[DELAY_FLAG_BIT]) |=> (state_q == S_WAIT && !wave_start_o))
		else $error("flagged slot did not idle");
	wave_index_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RQ3
		(state_q == S_DECO && slot_data != 8'h00 && !slot_data[DELAY_FLAG_BIT])
		|=> (wave_start_o && wave_index_o == $past(slot_data[ENTRY_MSB:0])))
		else $error("wave index mismatch");
	advance_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RQ5
		(state_q == S_PLAY && wave_done_i && idx_q != 3'h7) |=> (idx_q == $past(idx_q) + 3'h1))
		else $error("slot did not advance");
	last_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RQ6
		(state_q inside {S_PLAY, S_WAIT} && state_d != state_q && idx_q == 3'h7)
		|=> state_q == S_IDLE)
		else $error("did not stop after eighth slot");
	step_count_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RQ2
		(state_q == S_WAIT && tick_q == 32'(STEP_CYCLES - 1) && steps_q != 7'h00)
		|=> (steps_q == $past(steps_q) - 7'h1 && tick_q == 32'h0))
		else $error("delay step miscounted");
	gap_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RQ8
		(state_q == S_WAIT && steps_q != 7'h00) |=> (state_q == S_WAIT && !wave_start_o))
		else $error("gap cut short");
	wait_next_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RQ9
		(state_q == S_WAIT && steps_q == 7'h00 && idx_q != 3'h7) |=> state_q == S_FETCH)
		else $error("wait did not continue");

	play_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) wave_start_o);
	wait_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) state_q == S_WAIT);
	zero_wait_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q == S_DECO && slot_data == 8'h80);
	full_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q == S_PLAY && idx_q == 3'h7 && wave_done_i);
endmodule

// >>> seq_slots_pkg.sv
// Package of offsets, field layout, reset values and timing for the slot sequencer
package seq_slots_pkg;
	localparam logic [7:0] TRIGGER_OFFSET    = 8'h0C;
	localparam logic [7:0] FIRST_SLOT_OFFSET = 8'h0F;
	localparam logic [7:0] LAST_SLOT_OFFSET  = 8'h16;
	localparam logic [7:0] SLOT_FIVE_OFFSET  = 8'h13;
	localparam logic [7:0] SLOT_SIX_OFFSET   = 8'h14;
	localparam int         TRIGGER_BIT       = 0;
	localparam int         DELAY_FLAG_BIT    = 7;
	localparam int         ENTRY_MSB         = 6;
	localparam int         SLOT_COUNT        = 8;
	localparam logic [7:0] SLOT_RESET        = 8'h00;
	localparam int         CLK_PERIOD_NS     = 8;
	localparam int         DELAY_STEP_MS     = 10;
	localparam int         DELAY_STEP_CYCLES = (DELAY_STEP_MS * 1000000) / CLK_PERIOD_NS;
endpackage

// >>> slot_store.sv
// Eight-entry slot memory with a registered read port
module slot_store
	import seq_slots_pkg::*;
#(
	parameter int DEPTH = SLOT_COUNT
)(
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     wr_en_i,
	input  wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
	input  wire logic [7:0]               wr_data_i,
	input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
	output logic      [7:0]               rd_data_o
);
	logic [7:0] mem_q [DEPTH];
	logic [7:0] mem_d [DEPTH];
	logic [7:0] rd_d;

	always_comb
	begin
		for (int i = 0; i < DEPTH; i++)
		begin
			mem_d[i] = mem_q[i];
		end
		if (wr_en_i)
		begin
			mem_d[wr_idx_i] = wr_data_i;
		end
		rd_d = mem_q[rd_idx_i];
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				mem_q[i] <= SLOT_RESET;
			end
			rd_data_o <= SLOT_RESET;
		end
		else
		begin
			mem_q     <= mem_d;
			rd_data_o <= rd_d;
		end
	end
endmodule

// >>> wave_engine_model.sv
// Waveform engine model: answers each start with a one-cycle done pulse after a lag
module wave_engine_model
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       start_i,
	input  wire logic [3:0] lag_i,
	output logic            done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_q;
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= 0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= (cnt_q == 1);
			if (start_i)
				cnt_q <= lag_i + 1;
			else if (cnt_q != 0)
				cnt_q <= cnt_q - 1;
		end
	end
endmodule

// >>> waveform_sequence_slots_bench.sv
// Self-checking bench for the slot sequencer
module waveform_sequence_slots_bench import seq_slots_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// Short delay step keeps wait slots to a few cycles
	localparam int STEP = 4;
	logic       core_clk_i  = 1'b0;
	logic       rst_n_i     = 1'b0;
	logic       reg_wr_i    = 1'b0;
	logic       reg_rd_i    = 1'b0;
	logic [7:0] reg_addr_i  = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic [6:0] wave_index_o;
	logic       wave_start_o;
	logic       wave_done_i;
	logic       playing_o;
	logic       idling_o;
	logic [3:0] lag = 4'h1;
	logic [6:0] starts[$];
	int         n_fail = 0;
	int         compares = 0;
	int         seed = 32'h718e;
	int         cyc = 0;
	int         idle_n = 0;
	int         play_n = 0;
	int         clash = 0;

	waveform_sequence_slots #(.STEP_CYCLES(STEP)) i_waveform_sequence_slots (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .wave_index_o(wave_index_o),
		.wave_start_o(wave_start_o), .wave_done_i(wave_done_i), .playing_o(playing_o),
		.idling_o(idling_o));
	wave_engine_model i_wave_engine_model (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.start_i(wave_start_o), .lag_i(lag), .done_o(wave_done_i));

	initial
	begin
		forever #4 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i)
	begin
		cyc++;
		if (wave_start_o === 1'b1)
			starts.push_back(wave_index_o);
		if (idling_o === 1'b1)
			idle_n++;
		if (playing_o === 1'b1)
			play_n++;
		if (wave_start_o === 1'b1 && idling_o === 1'b1)
			clash++;
		if (playing_o === 1'b1 && idling_o === 1'b1)
			clash++;
		if (cyc == 60000)
		begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge core_clk_i);
		d = reg_rdata_o;
	endtask

	task automatic give_verdict();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		logic [7:0] d;
		logic [7:0] s[8];
		logic [6:0] eq[$];
		logic [31:0] r;
		int ei;
		int zp;
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd(SLOT_FIVE_OFFSET, d);
		chk(d, SLOT_RESET);
		rd(SLOT_SIX_OFFSET, d);
		chk(d, SLOT_RESET);
		rd(TRIGGER_OFFSET, d);
		chk(d, 8'h00);
		// Upper trigger bits are plain storage; bit 0 clear keeps the sequencer idle
		wr(TRIGGER_OFFSET, 8'hA4);
		rd(TRIGGER_OFFSET, d);
		chk(d, 8'hA4);
		wr(8'h20, 8'hFF);
		rd(8'h20, d);
		chk(d, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			r = $random(seed);
			wr(SLOT_FIVE_OFFSET, r[7:0]);
			wr(SLOT_SIX_OFFSET, r[15:8]);
			rd(SLOT_FIVE_OFFSET, d);
			chk(d, r[7:0]);
			rd(SLOT_SIX_OFFSET, d);
			chk(d, r[15:8]);
		end
		$display("test registers done");
		// Run 0 stops on the first slot, run 1 walks all eight
		for (int t = 0; t < 6; t++)
		begin
			for (int i = 0; i < 8; i++)
			begin
				r = $random(seed);
				s[i] = (r[1:0] == 2'b00) ? {6'h20, r[5:4] | 2'b01} : {1'b0, r[14:8] | 7'h01};
			end
			zp = (t < 2) ? t * 8 : {$random(seed)} % 9;
			if (t == 2)
			begin
				s[4] = 8'h2A;
				s[5] = 8'h82;
				s[6] = 8'h80;
			end
			if (zp < 8)
				s[zp] = 8'h00;
			eq.delete();
			ei = 0;
			for (int i = 0; i < 8 && s[i] != 8'h00; i++)
			begin
				if (s[i][DELAY_FLAG_BIT])
					ei += s[i][ENTRY_MSB:0] * STEP;
				else
					eq.push_back(s[i][ENTRY_MSB:0]);
			end
			for (int i = 0; i < 8; i++)
				wr(FIRST_SLOT_OFFSET + 8'(i), s[i]);
			lag <= 4'($random(seed));
			starts.delete();
			idle_n = 0;
			play_n = 0;
			clash = 0;
			wr(TRIGGER_OFFSET, 8'h01);
			for (int k = 0; k < 3000; k++)
			begin
				rd(TRIGGER_OFFSET, d);
				if (d[TRIGGER_BIT] === 1'b0)
					break;
			end
			chk(starts.size(), eq.size());
			for (int i = 0; i < eq.size() && i < starts.size(); i++)
				chk(starts[i], eq[i]);
			chk(idle_n, ei);
			// Engine model answers a start with done lag+2 cycles into the play state
			chk(play_n, eq.size() * (lag + 2));
			chk(clash, 0);
			$display("test run %0d done", t);
		end
		// Reset in the middle of a wait must clear slots, trigger and outputs
		for (int i = 0; i < 8; i++)
			wr(FIRST_SLOT_OFFSET + 8'(i), 8'h83);
		wr(TRIGGER_OFFSET, 8'h01);
		repeat (6) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk(idling_o, 1'b1);
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(negedge core_clk_i);
		chk({wave_start_o, playing_o, idling_o}, 3'h0);
		rd(SLOT_FIVE_OFFSET, d);
		chk(d, SLOT_RESET);
		rd(TRIGGER_OFFSET, d);
		chk(d, 8'h00);
		$display("test reset done");
		give_verdict();
	end
endmodule
